/* hw/adc_seq_pkg.sv */
`default_nettype none
package adc_seq_pkg;
    // Conversion and acquisition timing at a 40 MHz core clock
    localparam int CLK_PERIOD_PS    = 25000;
    localparam int CONV_TIME_PS     = 2400000;
    localparam int CONV_CYCLES      = (CONV_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACQ_TIME_PS      = 350000;
    localparam int ACQ_CYCLES       = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int QUIET_TIME_PS    = 100000;
    localparam int QUIET_CYCLES     = (QUIET_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Bit periods per conversion when the external clock is used
    localparam int EXT_CONV_EDGES   = 16;
    localparam int START_LOW_CYCLES = 2;
    localparam int EOC_LOW_CYCLES   = 2;
    // Widths
    localparam int NCHAN            = 4;
    localparam int DWIDTH           = 14;
    // Register map on the Avalon-MM side (word addresses)
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_STAT   = 4'h1;
    localparam logic [3:0] A_IRQ    = 4'h2;
    localparam logic [3:0] A_MASK   = 4'h3;
    localparam logic [3:0] A_CHSEL  = 4'h4;
    localparam logic [3:0] A_RES0   = 4'h8;
    // Control bits
    localparam int CTRL_START       = 0;
    localparam int CTRL_LOADSEL     = 1;
    // Interrupt bits and register reset values
    localparam int IRQ_EOC          = 0;
    localparam int IRQ_DONE         = 1;
    localparam logic [1:0] IRQ_RST  = 2'h0;
    localparam logic [3:0] CHSEL_RST = 4'hf;
endpackage
`default_nettype wire

/* hw/adc_bus_if.sv */
`default_nettype none
// Parallel link between converter and its controller
interface adc_bus_if;
    logic        conv_start_n;       // Start strobe, rising edge samples
    logic [3:0]  chan_pick_pins;     // Hardware channel pick
    logic        sw_select;          // High: channel register wins
    logic        clock_source_select;// High: external clock times conversion
    logic        ext_clock_in;       // External conversion clock
    logic        cs_n;               // Chip select
    logic        rd_n;               // Read strobe
    logic        wr_n;               // Write strobe
    logic [13:0] host_dout;          // Host drive of data lines
    logic        host_doe;           // Host drives data lines
    logic [13:0] dev_dout;           // Device drive of data lines
    logic        dev_doe;            // Device drives data lines
    logic        busy;               // Sequence in progress
    logic        eoc_n;              // End of each conversion
    modport device (input conv_start_n, chan_pick_pins, sw_select, clock_source_select, ext_clock_in,
                    cs_n, rd_n, wr_n, host_dout, host_doe,
                    output dev_dout, dev_doe, busy, eoc_n);
    modport host (output conv_start_n, chan_pick_pins, sw_select, clock_source_select, ext_clock_in,
                  cs_n, rd_n, wr_n, host_dout, host_doe,
                  input dev_dout, dev_doe, busy, eoc_n);
endinterface
`default_nettype wire

/* hw/adc_conv_device.sv */
// Notes on behaviour
// R1: Host starts conversion; start rising edge counts.
// R2: Start edge holds all four, converts selected.
// R3: Select low uses pins, high uses register.
// R4: Host writes selection on low data lines.
// R5: Data bit 0 is channel 1 upward.
// R6: Selection latched at start edge only.
// R7: Busy rises at start, stays until done.
// R8: Internal timing default; select high uses external.
// R9: Low end-of-conversion pulse after each channel.
// R10: Sequence end drops busy, resumes tracking.
// R11: Host reads after busy or each pulse.
// R12: Results move on 14-bit bus, strobed.
// R13: Internal clock conversion takes 2.4 us.
// R14: Host avoids reads during conversion, pre-start.
// R15: Host waits acquisition time before start.
// R16: Four channels support 100 kHz throughput.
// R17: Channels convert in ascending order, skipping unselected.
`default_nettype none
module adc_conv_device
    import adc_seq_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rstn,
    adc_bus_if.device          bus,
    input  wire logic [13:0]   sample_in [4],    // Analog stand-in, one word per channel
    output logic               tracking          // High while track/holds track
);
    typedef enum logic [1:0] {S_IDLE, S_CONV, S_NEXT} dstate_t;

    // Two-stage synchronisers for every pin input except the data lines
    logic [1:0]  start_sync_ff;
    logic [1:0]  ext_sync_ff;
    logic [1:0]  cs_sync_ff, rd_sync_ff, wr_sync_ff;
    logic [3:0]  pick_meta_ff, pick_sync_ff;
    logic        sel_meta_ff, sel_sync_ff, src_meta_ff, src_sync_ff;
    logic        start_d_ff;                     // Delayed start for edge detect
    logic        ext_d_ff;                       // Delayed external clock
    logic        wr_d_ff;                        // Delayed write strobe for edge detect
    logic        cs_d_ff;                        // Chip select one cycle before write rise
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            start_sync_ff <= 2'h3; ext_sync_ff <= 2'h0;
            cs_sync_ff <= 2'h3; rd_sync_ff <= 2'h3; wr_sync_ff <= 2'h3;
            pick_meta_ff <= 4'h0; pick_sync_ff <= 4'h0;
            sel_meta_ff <= 1'b0; sel_sync_ff <= 1'b0; src_meta_ff <= 1'b0; src_sync_ff <= 1'b0;
            start_d_ff <= 1'b1; ext_d_ff <= 1'b0;
            wr_d_ff <= 1'b1; cs_d_ff <= 1'b1;
        end else begin
            start_sync_ff <= {start_sync_ff[0], bus.conv_start_n};
            ext_sync_ff   <= {ext_sync_ff[0], bus.ext_clock_in};
            cs_sync_ff    <= {cs_sync_ff[0], bus.cs_n};
            rd_sync_ff    <= {rd_sync_ff[0], bus.rd_n};
            wr_sync_ff    <= {wr_sync_ff[0], bus.wr_n};
            pick_meta_ff  <= bus.chan_pick_pins; pick_sync_ff <= pick_meta_ff;
            sel_meta_ff   <= bus.sw_select;      sel_sync_ff  <= sel_meta_ff;
            src_meta_ff   <= bus.clock_source_select; src_sync_ff <= src_meta_ff;
            start_d_ff    <= start_sync_ff[1];
            ext_d_ff      <= ext_sync_ff[1];
            wr_d_ff       <= wr_sync_ff[1];
            cs_d_ff       <= cs_sync_ff[1];
        end
    end

    // Decoded events
    wire start_rise = start_sync_ff[1] & ~start_d_ff;                 // [R2]
    wire ext_rise   = ext_sync_ff[1] & ~ext_d_ff;
    // Write strobe rising while chip select was still low; only the second flop is read
    wire wr_rise    = wr_sync_ff[1] & ~wr_d_ff & ~cs_d_ff;               // [R4]
    wire rd_active  = ~cs_sync_ff[1] & ~rd_sync_ff[1];

    // Channel register and sequencer state
    logic [3:0]   chreg_ff;                      // Software channel select
    logic [3:0]   pend_ff;                       // Channels still to convert
    logic [13:0]  held_ff [4];                   // Values in hold
    logic [13:0]  result_ff [4];                 // Finished results
    logic [1:0]   chan_ff;                       // Channel in conversion
    logic [1:0]   rdptr_ff;                      // Next result to read
    logic [3:0]   done_ff;                       // Results waiting to be read
    logic [6:0]   tick_ff;                       // Conversion timer
    logic [1:0]   eoc_cnt_ff;                    // End pulse width
    logic         rd_d_ff;                       // Read strobe seen last cycle
    dstate_t      state_ff;

    wire [3:0] sel_src  = sel_sync_ff ? chreg_ff : pick_sync_ff;      // [R3]
    wire [6:0] tick_end = src_sync_ff ? 7'(EXT_CONV_EDGES - 1) : 7'(CONV_CYCLES - 1); // [R8] [R13]
    wire       tick_go  = src_sync_ff ? ext_rise : 1'b1;              // [R8]
    // Lowest pending channel picks next
    wire [1:0] first_ch = pend_ff[0] ? 2'd0 : pend_ff[1] ? 2'd1 : pend_ff[2] ? 2'd2 : 2'd3; // [R17]
    wire [1:0] first_rd = done_ff[0] ? 2'd0 : done_ff[1] ? 2'd1 : done_ff[2] ? 2'd2 : 2'd3; // [R17]

    // Channel register write from low data lines
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) chreg_ff <= CHSEL_RST;
        else if (wr_rise) chreg_ff <= bus.host_dout[3:0];                // [R5]
    end

    // Sequencer
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= S_IDLE; pend_ff <= 4'h0; chan_ff <= 2'd0; tick_ff <= 7'h0;
            eoc_cnt_ff <= 2'h0; done_ff <= 4'h0; rdptr_ff <= 2'd0; rd_d_ff <= 1'b0;
            for (int i = 0; i < NCHAN; i++) begin
                held_ff[i] <= 14'h0; result_ff[i] <= 14'h0;
            end
        end else begin
            rd_d_ff <= rd_active;
            if (eoc_cnt_ff != 2'h0) eoc_cnt_ff <= eoc_cnt_ff - 2'h1;
            // Read end advances to next waiting result
            if (rd_d_ff && !rd_active && done_ff != 4'h0) begin
                done_ff[rdptr_ff] <= 1'b0;
            end
            rdptr_ff <= first_rd;
            unique case (state_ff)
                S_IDLE: if (start_rise && sel_src != 4'h0) begin
                    pend_ff  <= sel_src;                                 // [R6]
                    done_ff  <= 4'h0;
                    for (int i = 0; i < NCHAN; i++) held_ff[i] <= sample_in[i]; // [R2]
                    state_ff <= S_NEXT;
                end
                S_NEXT: begin
                    chan_ff <= first_ch;                                  // [R17]
                    tick_ff <= 7'h0;
                    state_ff <= S_CONV;
                end
                S_CONV: if (tick_go) begin
                    if (tick_ff == tick_end) begin
                        result_ff[chan_ff] <= held_ff[chan_ff];
                        done_ff[chan_ff]   <= 1'b1;
                        pend_ff[chan_ff]   <= 1'b0;
                        eoc_cnt_ff <= 2'(EOC_LOW_CYCLES);                // [R9]
                        state_ff   <= (pend_ff == (4'h1 << chan_ff)) ? S_IDLE : S_NEXT; // [R10]
                    end else tick_ff <= tick_ff + 7'h1;
                end
            endcase
        end
    end

    // Output registers
    logic        busy_ff, eoc_n_ff, doe_ff, track_ff;
    logic [13:0] dout_ff;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_ff <= 1'b0; eoc_n_ff <= 1'b1; doe_ff <= 1'b0; dout_ff <= 14'h0; track_ff <= 1'b1;
        end else begin
            busy_ff  <= (state_ff != S_IDLE) || (start_rise && sel_src != 4'h0); // [R7] [R10]
            track_ff <= (state_ff == S_IDLE) && !(start_rise && sel_src != 4'h0); // [R10]
            eoc_n_ff <= (eoc_cnt_ff == 2'h0);                           // [R9]
            doe_ff   <= rd_active;                                       // [R12]
            dout_ff  <= result_ff[first_rd];                             // [R12]
        end
    end
    assign bus.busy     = busy_ff;
    assign bus.eoc_n    = eoc_n_ff;
    assign bus.dev_doe  = doe_ff;
    assign bus.dev_dout = dout_ff;
    assign tracking     = track_ff;
endmodule
`default_nettype wire

/* hw/adc_host_ctrl.sv */
`default_nettype none
module adc_host_ctrl
    import adc_seq_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rstn,
    adc_bus_if.host            bus,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    output logic               irq,
    input  wire logic [3:0]    pick_in,          // Hardware pick to drive on pins
    input  wire logic          sw_mode,          // Use channel register
    input  wire logic          ext_clk_mode      // Use external clock
);
    typedef enum logic [2:0] {H_IDLE, H_START, H_ACQ, H_WAIT, H_RD, H_WR, H_GAP} hstate_t;

    logic [1:0] busy_s_ff, eoc_s_ff;             // Synchronised device outputs
    logic       eoc_d_ff, busy_d_ff;
    logic [3:0] chsel_ff;                        // Software channel select
    logic [1:0] irq_ff, mask_ff;
    logic [13:0] res_ff [4];
    logic [3:0] rdsel_ff;                        // Channels left to read
    logic [1:0] rdch_ff;
    logic [4:0] cnt_ff;
    logic       start_req_ff, load_req_ff;
    logic       cs_n_ff, rd_n_ff, wr_n_ff, cv_n_ff, doe_ff, ext_ff, irq_o_ff;
    logic       wait_ff;
    logic [31:0] rdata_ff;
    hstate_t    st_ff;

    wire eoc_fall  = eoc_d_ff & ~eoc_s_ff[1];
    wire busy_fall = busy_d_ff & ~busy_s_ff[1];
    wire sel_w     = avs_write & wait_ff;
    wire wr_ctrl   = sel_w && avs_address == A_CTRL;
    wire [3:0] used = sw_mode ? chsel_ff : pick_in;
    wire [1:0] nxt_ch = rdsel_ff[0] ? 2'd0 : rdsel_ff[1] ? 2'd1 : rdsel_ff[2] ? 2'd2 : 2'd3;
    wire [31:0] rsel = (avs_address == A_STAT)  ? {30'h0, busy_s_ff[1], st_ff != H_IDLE} :
                       (avs_address == A_IRQ)   ? {30'h0, irq_ff} :
                       (avs_address == A_MASK)  ? {30'h0, mask_ff} :
                       (avs_address == A_CHSEL) ? {28'h0, chsel_ff} :
                       (avs_address[3])         ? {18'h0, res_ff[avs_address[1:0]]} : 32'h0;

    // Synchronise device outputs, free-running clock source for device
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            busy_s_ff <= 2'h0; eoc_s_ff <= 2'h3; eoc_d_ff <= 1'b1; busy_d_ff <= 1'b0; ext_ff <= 1'b0;
        end else begin
            busy_s_ff <= {busy_s_ff[0], bus.busy};
            eoc_s_ff  <= {eoc_s_ff[0], bus.eoc_n};
            eoc_d_ff  <= eoc_s_ff[1];
            busy_d_ff <= busy_s_ff[1];
            ext_ff    <= ~ext_ff;
        end
    end

    // Avalon slave: one wait cycle, answer on second edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_ff <= 1'b0; rdata_ff <= 32'h0; chsel_ff <= CHSEL_RST; mask_ff <= 2'h0; irq_ff <= IRQ_RST;
            start_req_ff <= 1'b0; load_req_ff <= 1'b0; irq_o_ff <= 1'b0;
        end else begin
            wait_ff  <= (avs_read | avs_write) & ~wait_ff;
            rdata_ff <= rsel;
            if (sel_w && avs_address == A_CHSEL) chsel_ff <= avs_writedata[3:0];
            if (sel_w && avs_address == A_MASK)  mask_ff  <= avs_writedata[1:0];
            // Hardware set wins over write-one clear
            irq_ff <= (irq_ff & ~((sel_w && avs_address == A_IRQ) ? avs_writedata[1:0] : 2'h0))
                      | {busy_fall, eoc_fall};
            irq_o_ff <= |(irq_ff & mask_ff);
            if (wr_ctrl && avs_writedata[CTRL_START]) start_req_ff <= 1'b1;
            else if (st_ff == H_START) start_req_ff <= 1'b0;
            if (wr_ctrl && avs_writedata[CTRL_LOADSEL]) load_req_ff <= 1'b1;
            else if (st_ff == H_WR) load_req_ff <= 1'b0;
        end
    end
    assign avs_waitrequest = ~wait_ff;
    assign avs_readdata    = rdata_ff;
    assign irq             = irq_o_ff;

    // Link sequencer: load, start, wait for busy, read results
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= H_IDLE; cnt_ff <= 5'h0; cs_n_ff <= 1'b1; rd_n_ff <= 1'b1; wr_n_ff <= 1'b1;
            cv_n_ff <= 1'b1; doe_ff <= 1'b0; rdsel_ff <= 4'h0; rdch_ff <= 2'd0;
            for (int i = 0; i < NCHAN; i++) res_ff[i] <= 14'h0;
        end else begin
            unique case (st_ff)
                H_IDLE: begin
                    cnt_ff <= 5'h0;
                    if (load_req_ff) begin
                        cs_n_ff <= 1'b0; wr_n_ff <= 1'b0; doe_ff <= 1'b1; st_ff <= H_WR;
                    end else if (start_req_ff && used != 4'h0) begin
                        cv_n_ff <= 1'b0; st_ff <= H_START;               // [R1]
                    end
                end
                H_WR: begin                                              // [R4]
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'h3) begin
                        wr_n_ff <= 1'b1; cs_n_ff <= 1'b1; st_ff <= H_GAP;
                    end
                end
                H_GAP: begin
                    doe_ff <= 1'b0; st_ff <= H_IDLE;
                end
                H_START: begin
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'(START_LOW_CYCLES - 1)) begin
                        cv_n_ff <= 1'b1; rdsel_ff <= used; cnt_ff <= 5'h0; st_ff <= H_WAIT; // [R1]
                    end
                end
                H_WAIT: if (busy_fall) begin                             // [R11] [R14]
                    rdch_ff <= nxt_ch; cnt_ff <= 5'h0; st_ff <= H_RD;
                    cs_n_ff <= 1'b0; rd_n_ff <= 1'b0;
                end
                H_RD: begin                                              // [R12]
                    cnt_ff <= cnt_ff + 5'h1;
                    if (cnt_ff == 5'h5) begin
                        res_ff[rdch_ff] <= bus.dev_dout;
                        rdsel_ff[rdch_ff] <= 1'b0;
                        cs_n_ff <= 1'b1; rd_n_ff <= 1'b1; st_ff <= H_ACQ; cnt_ff <= 5'h0;
                    end
                end
                H_ACQ: begin                                             // [R15]
                    cnt_ff <= cnt_ff + 5'h1;
                    if (rdsel_ff != 4'h0 && cnt_ff == 5'h3) begin
                        rdch_ff <= nxt_ch; cnt_ff <= 5'h0; cs_n_ff <= 1'b0; rd_n_ff <= 1'b0; st_ff <= H_RD;
                    end else if (rdsel_ff == 4'h0 && cnt_ff == 5'(ACQ_CYCLES + QUIET_CYCLES)) begin
                        st_ff <= H_IDLE;                                 // [R16]
                    end
                end
                default: st_ff <= H_IDLE;
            endcase
        end
    end
    assign bus.conv_start_n        = cv_n_ff;
    assign bus.chan_pick_pins      = pick_in;
    assign bus.sw_select           = sw_mode;
    assign bus.clock_source_select = ext_clk_mode;
    assign bus.ext_clock_in        = ext_ff;
    assign bus.cs_n                = cs_n_ff;
    assign bus.rd_n                = rd_n_ff;
    assign bus.wr_n                = wr_n_ff;
    assign bus.host_doe            = doe_ff;
    assign bus.host_dout           = {10'h0, chsel_ff};
endmodule
`default_nettype wire

/* bench/adc_seq_chk.sv */
`default_nettype none
module adc_seq_chk
    import adc_seq_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic conv_start_n,
    input  wire logic cs_n,
    input  wire logic rd_n,
    input  wire logic wr_n,
    input  wire logic host_doe,
    input  wire logic dev_doe,
    input  wire logic busy,
    input  wire logic eoc_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [9:0] busy_cnt_ff;  // Cycles spent busy in the current sequence
    logic [9:0] nxt_busy_cnt; // Next count, cleared while idle
    assign nxt_busy_cnt = busy ? busy_cnt_ff + 10'h001 : 10'h000;
    // Busy length counter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn)
            busy_cnt_ff <= 10'h000;
        else
            busy_cnt_ff <= nxt_busy_cnt;
    end
    a_start_pulse_len: assert property ($fell(conv_start_n) |=> !conv_start_n ##1 conv_start_n)
        else $error("start strobe not two cycles low");
    a_busy_after_start: assert property ($rose(conv_start_n) |-> ##[1:6] busy)
        else $error("busy did not follow start");
    a_busy_bounded: assert property (busy_cnt_ff <= 10'h1a8)
        else $error("sequence ran too long");
    a_eoc_pulse_len: assert property ($fell(eoc_n) |=> !eoc_n ##1 eoc_n)
        else $error("end-of-conversion pulse not two cycles");
    a_eoc_in_seq: assert property ($fell(eoc_n) |-> busy || $past(busy))
        else $error("end-of-conversion outside a sequence");
    a_acq_wait: assert property ($fell(busy) |-> conv_start_n[*8])
        else $error("start too soon after sequence end");
    a_read_after_busy: assert property (!rd_n |-> !busy)
        else $error("read during conversion");
    a_no_data_fight: assert property (!(dev_doe && host_doe))
        else $error("both ends drive data lines");
    a_doe_needs_read: assert property (dev_doe |-> !rd_n || !$past(rd_n) || !$past(rd_n, 2) || !$past(rd_n, 3))
        else $error("device drives data without a read");
    a_write_framed: assert property ($fell(wr_n) |-> (!wr_n && !cs_n)[*4] ##1 wr_n)
        else $error("write strobe framing wrong");
    a_read_framed: assert property ($fell(rd_n) |-> (!rd_n && !cs_n)[*6] ##1 rd_n)
        else $error("read strobe framing wrong");
    // Main scenarios reached
    c_seq_done: cover property ($fell(busy));
    c_eoc_seen: cover property ($fell(eoc_n));
    c_reg_write: cover property ($fell(wr_n));
endmodule
`default_nettype wire

/* bench/simul_sample_adc_sequencer_tb.sv */
`default_nettype none
module simul_sample_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_seq_pkg::*;
    logic        core_clk;      // 40 MHz clock
    logic        rstn;          // Reset, active low
    logic [3:0]  avs_address;   // Register bus
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;           // Level interrupt
    logic [3:0]  pick_in;       // Hardware channel pick
    logic        sw_mode;       // Register selects channels
    logic        ext_clk_mode;  // External conversion clock
    logic [13:0] sample_in [4]; // Analog stand-in
    logic        tracking;      // Track/holds tracking
    int          n_errors;      // Mismatches
    int          checked;       // Comparisons
    int          eoc_low;       // Cycles with end-of-conversion low
    adc_bus_if bus_if();
    adc_conv_device i_adc_conv_device(.core_clk(core_clk), .rstn(rstn), .bus(bus_if), .sample_in(sample_in),
        .tracking(tracking));
    adc_host_ctrl i_adc_host_ctrl(.core_clk(core_clk), .rstn(rstn), .bus(bus_if), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .pick_in(pick_in), .sw_mode(sw_mode),
        .ext_clk_mode(ext_clk_mode));
    adc_seq_chk i_adc_seq_chk(.core_clk(core_clk), .rstn(rstn), .conv_start_n(bus_if.conv_start_n),
        .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .host_doe(bus_if.host_doe),
        .dev_doe(bus_if.dev_doe), .busy(bus_if.busy), .eoc_n(bus_if.eoc_n));
    // Clock
    always #12.5 core_clk = ~core_clk;
    // Count end-of-conversion low cycles
    always @(posedge core_clk) begin
        if (bus_if.eoc_n === 1'b0) eoc_low++;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // One bus cycle; held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 50) n_errors++;
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic av_wr(input logic [3:0] a, input logic [31:0] wd);
        logic [31:0] d;
        av_xfer(1'b1, a, wd, d);
    endtask
    // Wait until neither end is busy
    task automatic idle();
        int n;
        logic [31:0] d;
        n = 0;
        d = 32'h1;
        while (d[1:0] !== 2'b00 && n < 200) begin
            av_xfer(1'b0, A_STAT, 32'h0, d);
            n++;
        end
    endtask
    // One sequence: busy span, pulses, tracking and results in channel order
    task automatic seq(input logic [3:0] pick, input logic [3:0] sel, input int min_c, input int max_c);
        int n;
        logic [31:0] d;
        n = 0;
        for (int i = 0; i < 4; i++) sample_in[i] <= sample_in[i] + 14'h0123 * 14'(i + 1);
        pick_in <= pick;
        idle();
        eoc_low = 0;
        av_wr(A_CTRL, 32'h1);
        while (bus_if.busy !== 1'b1 && n < 80) begin
            @(posedge core_clk);
            n++;
        end
        @(posedge core_clk);
        check("tracking in hold", {31'h0, tracking}, 32'h0);
        pick_in <= ~pick;
        n = 1;
        while (bus_if.busy === 1'b1 && n < 1000) begin
            @(posedge core_clk);
            n++;
        end
        check("busy span", {31'h0, n >= min_c && n <= max_c}, 32'h1);
        @(posedge core_clk);
        check("tracking after end", {31'h0, tracking}, 32'h1);
        idle();
        check("eoc low cycles", eoc_low, 2 * $countones(sel));
        for (int c = 0; c < 4; c++) begin
            if (sel[c]) begin
                av_xfer(1'b0, A_RES0 + 4'(c), 32'h0, d);
                check("result word", d, {18'h0, sample_in[c]});
            end
        end
    endtask
    // Reset state, channel select default, unmapped place
    task automatic t_reset();
        logic [31:0] d;
        check("busy", {31'h0, bus_if.busy}, 32'h0);
        check("eoc_n", {31'h0, bus_if.eoc_n}, 32'h1);
        check("irq", {31'h0, irq}, 32'h0);
        av_xfer(1'b0, A_CHSEL, 32'h0, d);
        check("chsel reset", d, {28'h0, CHSEL_RST});
        av_xfer(1'b0, 4'h5, 32'h0, d);
        check("unmapped read", d, 32'h0);
    endtask
    // Hardware pick, selection changed mid-sequence, interrupt raised and cleared
    task automatic t_hw();
        logic [31:0] d;
        av_wr(A_MASK, 32'h3);
        seq(4'h5, 4'h5, 2 * CONV_CYCLES, 2 * CONV_CYCLES + 40);
        check("irq raised", {31'h0, irq}, 32'h1);
        av_xfer(1'b0, A_IRQ, 32'h0, d);
        check("irq status", d, 32'h3);
        av_wr(A_IRQ, 32'h3);
        av_xfer(1'b0, A_IRQ, 32'h0, d);
        check("irq cleared", d, 32'h0);
        check("irq low", {31'h0, irq}, 32'h0);
    endtask
    // Register selection over the link, interrupt masked
    task automatic t_sw();
        logic [31:0] d;
        av_wr(A_MASK, 32'h0);
        av_wr(A_CHSEL, 32'he);
        av_wr(A_CTRL, 32'h2);
        sw_mode <= 1'b1;
        seq(4'h1, 4'he, 3 * CONV_CYCLES, 3 * CONV_CYCLES + 40);
        check("irq masked", {31'h0, irq}, 32'h0);
        av_wr(A_IRQ, 32'h3);
    endtask
    // External clock, all four channels
    task automatic t_ext();
        sw_mode <= 1'b0;
        ext_clk_mode <= 1'b1;
        seq(4'hf, 4'hf, 4 * EXT_CONV_EDGES, 2 * CONV_CYCLES);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (30000) @(posedge core_clk);
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        pick_in = 4'h1;
        sw_mode = 1'b0;
        ext_clk_mode = 1'b0;
        n_errors = 0;
        checked = 0;
        eoc_low = 0;
        for (int i = 0; i < 4; i++) sample_in[i] = 14'h1a5a + 14'h0b11 * 14'(i);
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_hw();
        t_sw();
        t_ext();
        conclude();
    end
endmodule
`default_nettype wire
